/* src/nvs_slave.v */
`timescale 1ns/1ps
`default_nettype none
`include "nvs_defs.vh"

module nvs_slave (
  // Clock and reset
  input  wire                     clock_i,
  input  wire                     nrst_i,
  // Serial link
  input  wire                     cs_n_i,
  input  wire                     sck_i,
  input  wire                     mosi_i,
  input  wire                     hold_n_i,
  output wire                     so_o,
  output wire                     so_oe_o,
  // Write protect
  input  wire                     wp_n_i,
  // Store busy pin
  input  wire                     store_busy_pin_i,
  output wire                     store_busy_pin_o,
  output wire                     store_busy_pin_oe_o,
  // Power loss warning
  input  wire                     power_fail_i,
  // Array read port
  output wire                     mem_rd_o,
  output wire [`NVS_ADDR_W-1:0]   mem_rd_addr_o,
  input  wire [7:0]               mem_rdata_i,
  // Array write port
  output wire                     mem_wr_valid_o,
  input  wire                     mem_wr_ready_i,
  output wire [`NVS_ADDR_W-1:0]   mem_wr_addr_o,
  output wire [7:0]               mem_wr_data_o,
  // Nonvolatile control
  output wire                     nv_store_o,
  output wire                     nv_recall_o,
  input  wire                     nv_done_i,
  // Status
  output wire                     busy_o,
  output wire                     write_enabled_o,
  output wire                     block_guard_bit0_o,
  output wire                     block_guard_bit1_o,
  output wire                     autosave_on_o,
  output wire                     overrun_o
);

  localparam [2:0] ST_CMD    = 3'h0;
  localparam [2:0] ST_ADDR   = 3'h1;
  localparam [2:0] ST_WDATA  = 3'h2;
  localparam [2:0] ST_RDATA  = 3'h3;
  localparam [2:0] ST_SRRD   = 3'h4;
  localparam [2:0] ST_SRWR   = 3'h5;
  localparam [2:0] ST_IGNORE = 3'h6;

  reg                   rst_s1_reg;
  reg                   rst_n_reg;
  reg [6:0]             sync1_reg;
  reg [6:0]             sync2_reg;
  reg                   sck_d_reg;
  reg [2:0]             state_reg;
  reg [2:0]             bit_cnt_reg;
  reg [1:0]             abyte_cnt_reg;
  reg [6:0]             rx_reg;
  reg [`NVS_ADDR_W-1:0] addr_reg;
  reg                   is_read_reg;
  reg [7:0]             tx_reg;
  reg [7:0]             rd_data_reg;
  reg                   mem_rd_reg;
  reg [`NVS_ADDR_W-1:0] mem_rd_addr_reg;
  reg                   rd_pend_reg;
  reg                   wel_reg;
  reg [1:0]             guard_reg;
  reg                   autosave_reg;
  reg                   dirty_reg;
  reg                   busy_reg;
  reg                   nv_store_reg;
  reg                   nv_recall_reg;
  reg                   overrun_reg;

  wire                   pf_s;
  wire                   hsb_s;
  wire                   wp_s;
  wire                   hold_s;
  wire                   mosi_s;
  wire                   sck_s;
  wire                   cs_s;
  wire                   buf_ready;
  wire [`NVS_ADDR_W-1:0] addr_full;
  wire [`NVS_ADDR_W-1:0] rd_addr;
  wire [7:0]             byte_in;

  function guarded;
    input [`NVS_ADDR_W-1:0] a;
    input [1:0]             g;
    begin
      case (g)
        `NVS_GUARD_QTR:  guarded = (a >= `NVS_QTR_BASE);
        `NVS_GUARD_HALF: guarded = (a >= `NVS_HALF_BASE);
        `NVS_GUARD_ALL:  guarded = 1'b1;
        default:         guarded = 1'b0;
      endcase
    end
  endfunction

  function [7:0] status_byte;
    input       busy;
    input       wel;
    input [1:0] g;
    input       autosave;
    reg   [7:0] s;
    begin
      s = `NVS_BYTE_ZERO;
      s[`NVS_SR_BUSY] = busy;
      s[`NVS_SR_WEL] = wel;
      s[`NVS_SR_GUARD_HI:`NVS_SR_GUARD_LO] = g;
      s[`NVS_SR_AUTOSAVE] = autosave;
      status_byte = s;
    end
  endfunction

  assign {pf_s, hsb_s, wp_s, hold_s, mosi_s, sck_s, cs_s} = sync2_reg;
  // Edges count only while selected and not held
  wire active    = ~cs_s & hold_s;
  wire sck_rise  = active & sck_s & ~sck_d_reg;
  wire sck_fall  = active & ~sck_s & sck_d_reg;
  wire byte_done = sck_rise & (bit_cnt_reg == `NVS_BIT_LAST);
  wire rd_state  = (state_reg == ST_RDATA) | (state_reg == ST_SRRD);
  wire opc_done  = byte_done & (state_reg == ST_CMD);
  wire abyte_last = (abyte_cnt_reg == `NVS_ABYTE_LAST);

  assign byte_in   = {rx_reg, mosi_s};
  assign addr_full = {addr_reg[`NVS_ADDR_W-9:0], byte_in};
  // Outside low on the pin, or power loss, also inhibits access
  wire blocked = busy_reg | ~hsb_s | pf_s;
  wire wr_ok   = wel_reg & wp_s & ~blocked & ~guarded(addr_reg, guard_reg);
  wire in_wr   = byte_done & (state_reg == ST_WDATA);
  wire push    = in_wr & wr_ok & buf_ready;
  wire rd_issue = byte_done & (((state_reg == ST_ADDR) & abyte_last & is_read_reg)
                  | (state_reg == ST_RDATA));
  assign rd_addr = (state_reg == ST_RDATA) ? addr_reg : addr_full;
  wire sw_store  = opc_done & (byte_in == `NVS_OP_STORE);
  wire sw_recall = opc_done & (byte_in == `NVS_OP_RECALL);
  // Conditional saves need a write since the last transfer
  wire hw_save   = dirty_reg & (~hsb_s | (pf_s & autosave_reg));
  wire store_go  = ~busy_reg & (sw_store | hw_save);
  wire recall_go = ~busy_reg & sw_recall & ~store_go;

  always @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      {rst_n_reg, rst_s1_reg} <= 2'h0;
    else
      {rst_n_reg, rst_s1_reg} <= {rst_s1_reg, 1'h1};
  always @(posedge clock_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      sync1_reg       <= `NVS_SYNC_IDLE;
      sync2_reg       <= `NVS_SYNC_IDLE;
      sck_d_reg       <= 1'b0;
      state_reg       <= ST_CMD;
      bit_cnt_reg     <= `NVS_BIT_FIRST;
      abyte_cnt_reg   <= `NVS_ABYTE_FIRST;
      rx_reg          <= 7'h00;
      addr_reg        <= {`NVS_ADDR_W{1'b0}};
      is_read_reg     <= 1'b0;
      tx_reg          <= `NVS_BYTE_ZERO;
      rd_data_reg     <= `NVS_BYTE_ZERO;
      mem_rd_reg      <= 1'b0;
      mem_rd_addr_reg <= {`NVS_ADDR_W{1'b0}};
      rd_pend_reg     <= 1'b0;
      wel_reg         <= 1'b0;
      guard_reg       <= `NVS_GUARD_RST;
      autosave_reg    <= `NVS_AUTOSAVE_RST;
      dirty_reg       <= 1'b0;
      busy_reg        <= 1'b0;
      nv_store_reg    <= 1'b0;
      nv_recall_reg   <= 1'b0;
      overrun_reg     <= 1'b0;
    end
    else
    begin
      sync1_reg     <= {power_fail_i, store_busy_pin_i, wp_n_i, hold_n_i, mosi_i, sck_i, cs_n_i};
      sync2_reg     <= sync1_reg;
      sck_d_reg     <= sck_s;
      mem_rd_reg    <= 1'b0;
      rd_pend_reg   <= mem_rd_reg;
      nv_store_reg  <= store_go;
      nv_recall_reg <= recall_go;
      if (rd_pend_reg)
        rd_data_reg <= mem_rdata_i;
      if (store_go || recall_go)
        busy_reg <= 1'b1;
      else if (nv_done_i)
        busy_reg <= 1'b0;
      if (push)
        dirty_reg <= 1'b1;
      else if (store_go || recall_go)
        dirty_reg <= 1'b0;
      if (in_wr && wr_ok && !buf_ready)
        overrun_reg <= 1'b1;
      else if (opc_done)
        overrun_reg <= 1'b0;
      if (rd_issue)
      begin
        mem_rd_reg      <= ~blocked;
        mem_rd_addr_reg <= rd_addr;
        if (blocked)
          rd_data_reg <= `NVS_REFUSED_BYTE;
      end
      if (cs_s)
      begin
        state_reg     <= ST_CMD;
        bit_cnt_reg   <= `NVS_BIT_FIRST;
        abyte_cnt_reg <= `NVS_ABYTE_FIRST;
      end
      else
      begin
        if (sck_rise)
        begin
          bit_cnt_reg <= bit_cnt_reg + `NVS_BIT_STEP;
          rx_reg      <= byte_in[6:0];
        end
        if (sck_fall && rd_state)
          tx_reg <= (bit_cnt_reg == `NVS_BIT_FIRST) ? rd_data_reg : {tx_reg[6:0], 1'b0};
        if (byte_done)
        begin
          case (state_reg)
            ST_CMD:
            begin
              state_reg <= ST_IGNORE;
              case (byte_in)
                `NVS_OP_READ:
                begin
                  state_reg   <= ST_ADDR;
                  is_read_reg <= 1'b1;
                end
                `NVS_OP_WRITE:
                begin
                  state_reg   <= ST_ADDR;
                  is_read_reg <= 1'b0;
                end
                `NVS_OP_RDSR:
                begin
                  state_reg   <= ST_SRRD;
                  rd_data_reg <= status_byte(busy_reg, wel_reg, guard_reg, autosave_reg);
                end
                `NVS_OP_WRSR:   state_reg <= ST_SRWR;
                `NVS_OP_WREN:   wel_reg <= 1'b1;
                `NVS_OP_WRITE_DISABLE_CMD:   wel_reg <= 1'b0;
                `NVS_OP_PLS_ON:  autosave_reg <= 1'b1;
                `NVS_OP_PLS_OFF: autosave_reg <= 1'b0;
                default:        state_reg <= ST_IGNORE;
              endcase
            end
            ST_ADDR:
            begin
              abyte_cnt_reg <= abyte_cnt_reg + `NVS_ABYTE_STEP;
              addr_reg      <= addr_full;
              if (abyte_last)
              begin
                state_reg <= is_read_reg ? ST_RDATA : ST_WDATA;
                if (is_read_reg)
                  addr_reg <= addr_full + `NVS_ADDR_INC;
              end
            end
            ST_WDATA, ST_RDATA: addr_reg <= addr_reg + `NVS_ADDR_INC;
            ST_SRRD:
              rd_data_reg <= status_byte(busy_reg, wel_reg, guard_reg, autosave_reg);
            ST_SRWR:
            begin
              state_reg <= ST_IGNORE;
              if (wel_reg && wp_s)
                guard_reg <= byte_in[`NVS_SR_GUARD_HI:`NVS_SR_GUARD_LO];
            end
            default: state_reg <= ST_IGNORE;
          endcase
        end
      end
    end
  end

  nvs_buf #(
    .WIDTH (`NVS_BUF_W),
    .DEPTH (`NVS_BUF_DEPTH)
  ) u_wr_buf (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_reg),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   ({addr_reg, byte_in}),
    .out_valid_o (mem_wr_valid_o),
    .out_ready_i (mem_wr_ready_i),
    .out_data_o  ({mem_wr_addr_o, mem_wr_data_o})
  );

  assign so_o                = tx_reg[7];
  assign so_oe_o             = active & rd_state;
  assign store_busy_pin_o    = 1'b0;
  assign store_busy_pin_oe_o = busy_reg;
  assign mem_rd_o            = mem_rd_reg;
  assign mem_rd_addr_o       = mem_rd_addr_reg;
  assign nv_store_o          = nv_store_reg;
  assign nv_recall_o         = nv_recall_reg;
  assign busy_o              = busy_reg;
  assign write_enabled_o     = wel_reg;
  assign block_guard_bit0_o  = guard_reg[0];
  assign block_guard_bit1_o  = guard_reg[1];
  assign autosave_on_o       = autosave_reg;
  assign overrun_o           = overrun_reg;

endmodule

`default_nettype wire

/* src/nvs_defs.vh */
`ifndef NVS_DEFS_VH
`define NVS_DEFS_VH

// Array geometry
`define NVS_ADDR_W        17
`define NVS_ADDR_INC      17'h00001
`define NVS_QTR_BASE      17'h18000
`define NVS_HALF_BASE     17'h10000

// Serial framing
`define NVS_BIT_FIRST     3'h0
`define NVS_BIT_STEP      3'h1
`define NVS_BIT_LAST      3'h7
`define NVS_ABYTE_FIRST   2'h0
`define NVS_ABYTE_STEP    2'h1
`define NVS_ABYTE_LAST    2'h2

// Command opcodes
`define NVS_OP_WRSR       8'h01
`define NVS_OP_WRITE      8'h02
`define NVS_OP_READ       8'h03
`define NVS_OP_WRITE_DISABLE_CMD       8'h04
`define NVS_OP_RDSR       8'h05
`define NVS_OP_WREN       8'h06
`define NVS_OP_PLS_OFF    8'h19
`define NVS_OP_STORE      8'h3C
`define NVS_OP_PLS_ON     8'h59
`define NVS_OP_RECALL     8'h60

// Block guard encodings
`define NVS_GUARD_NONE    2'h0
`define NVS_GUARD_QTR     2'h1
`define NVS_GUARD_HALF    2'h2
`define NVS_GUARD_ALL     2'h3

// Status byte layout
`define NVS_SR_BUSY       0
`define NVS_SR_WEL        1
`define NVS_SR_GUARD_LO   2
`define NVS_SR_GUARD_HI   3
`define NVS_SR_AUTOSAVE   6

// Reset values and fill
`define NVS_AUTOSAVE_RST  1'b1
`define NVS_GUARD_RST     2'h0
// Pin idle levels: power fail low, all others high
`define NVS_SYNC_IDLE     7'h3F
`define NVS_BYTE_ZERO     8'h00
`define NVS_REFUSED_BYTE  8'h00

// Write buffer shape
`define NVS_BUF_W         25
`define NVS_BUF_DEPTH     2

`endif

/* src/nvs_buf.v */
`timescale 1ns/1ps
`default_nettype none
`include "nvs_defs.vh"

module nvs_buf #(
  parameter WIDTH = `NVS_BUF_W,
  parameter DEPTH = `NVS_BUF_DEPTH
) (
  // Clock and reset
  input  wire             clock_i,
  input  wire             rst_n_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] slot_reg [0:DEPTH-1];
  reg             wr_ptr_reg;
  reg             rd_ptr_reg;
  reg [1:0]       count_reg;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (count_reg != DEPTH[1:0]);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = slot_reg[rd_ptr_reg];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_slot
      always @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          slot_reg[gi] <= {WIDTH{1'b0}};
        else if (push && (wr_ptr_reg == gi[0]))
          slot_reg[gi] <= in_data_i;
      end
    end
  endgenerate

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        count_reg <= count_reg + 2'h1;
      else if (pop && !push)
        count_reg <= count_reg - 2'h1;
    end
  end

endmodule

`default_nettype wire

/* sim/nvs_slave_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module nvs_slave_checker (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        cs_n_i,
  input wire logic        sck_i,
  input wire logic        wp_n_i,
  input wire logic        so_o,
  input wire logic        so_oe_o,
  input wire logic        store_busy_pin_o,
  input wire logic        store_busy_pin_oe_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_valid_o,
  input wire logic        mem_wr_ready_i,
  input wire logic [16:0] mem_wr_addr_o,
  input wire logic [7:0]  mem_wr_data_o,
  input wire logic        nv_store_o,
  input wire logic        nv_recall_o,
  input wire logic        nv_done_i,
  input wire logic        busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_nv_go;
    nv_store_o || nv_recall_o;
  endsequence
  sequence s_nv_end;
    busy_o && nv_done_i;
  endsequence
  property p_idle;
    cs_n_i [*6] |-> !so_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("serial out on while idle");
  property p_go;
    s_nv_go |-> busy_o && store_busy_pin_oe_o;
  endproperty
  a_go: assert property (p_go) else $error("busy late at transfer start");
  property p_pin;
    busy_o == store_busy_pin_oe_o && !store_busy_pin_o;
  endproperty
  a_pin: assert property (p_pin) else $error("busy pin out of step");
  property p_end;
    s_nv_end |=> !busy_o && !store_busy_pin_oe_o;
  endproperty
  a_end: assert property (p_end) else $error("busy stuck after done");
  property p_keep;
    busy_o && !nv_done_i |=> busy_o;
  endproperty
  a_keep: assert property (p_keep) else $error("busy dropped early");
  property p_restart;
    $past(busy_o) && busy_o |-> !nv_store_o && !nv_recall_o;
  endproperty
  a_restart: assert property (p_restart) else $error("transfer restarted");
  property p_wp;
    !wp_n_i [*8] |-> !$rose(mem_wr_valid_o);
  endproperty
  a_wp: assert property (p_wp) else $error("write under protect");
  property p_wr;
    mem_wr_valid_o && !mem_wr_ready_i |=>
      mem_wr_valid_o && $stable(mem_wr_addr_o) && $stable(mem_wr_data_o);
  endproperty
  a_wr: assert property (p_wr) else $error("write word lost");
  property p_rd;
    mem_rd_o |=> !mem_rd_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe too long");
  property p_so;
    so_oe_o && $changed(so_o) |-> !$past(sck_i, 2);
  endproperty
  a_so: assert property (p_so) else $error("serial out moved off falling edge");
endmodule
bind nvs_slave nvs_slave_checker u_chk (.clock_i, .nrst_i, .cs_n_i, .sck_i, .wp_n_i, .so_o,
  .so_oe_o, .store_busy_pin_o, .store_busy_pin_oe_o, .mem_rd_o, .mem_wr_valid_o,
  .mem_wr_ready_i, .mem_wr_addr_o, .mem_wr_data_o, .nv_store_o, .nv_recall_o, .nv_done_i,
  .busy_o);
`default_nettype wire

/* sim/nvs_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module nvs_spi_host (
  input  wire logic clock_i,
  input  wire logic miso_i,
  output var logic  cs_n_o,
  output var logic  sck_o,
  output var logic  mosi_o,
  output var logic  hold_n_o
);
  logic m3;
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
    hold_n_o = 1'b1;
    m3 = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clock_i);
  endtask
  // Idle clock level selects mode 0 or 3
  task automatic start(input logic mode3);
    m3 = mode3;
    sck_o = mode3;
    half();
    cs_n_o = 1'b0;
    half();
  endtask
  // MSB first; set while clock low, sample at end of high half
  task automatic xfer(input logic [7:0] b, input logic hld, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      sck_o = 1'b0;
      mosi_o = b[i];
      half();
      if (hld && i == 3)
      begin
        hold_n_o = 1'b0;
        repeat (24) @(negedge clock_i);
        hold_n_o = 1'b1;
        half();
      end
      sck_o = 1'b1;
      half();
      r = {r[6:0], miso_i};
    end
  endtask
  task automatic stop();
    sck_o = m3;
    half();
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    half();
  endtask
endmodule
`default_nettype wire

/* sim/nvs_slave_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module nvs_slave_tb_top;
  logic        clock_i, nrst_i, wp_n_i, power_fail_i, mem_wr_ready_i, nv_done_i;
  logic        ext_low, stall_on, miso_t;
  logic [7:0]  mem_rdata_i, r, old;
  logic [16:0] a;
  logic [31:0] seed = 32'hD6EB0BD8;
  logic [31:0] stall = 32'hD6EB0BD8;
  logic [7:0]  mem [0:131071];
  logic [7:0]  dq [8];
  logic [7:0]  rq [8];
  int          miscompares = 0, cmp_count = 0, st_cnt = 0, rc_cnt = 0, nv_t = 0, c0;
  wire         cs_n_i, sck_i, mosi_i, hold_n_i, so_o, so_oe_o, store_busy_pin_o;
  wire         store_busy_pin_oe_o, mem_rd_o, mem_wr_valid_o, nv_store_o, nv_recall_o;
  wire         busy_o, write_enabled_o, block_guard_bit0_o, block_guard_bit1_o;
  wire         autosave_on_o, overrun_o;
  wire  [16:0] mem_rd_addr_o, mem_wr_addr_o;
  wire  [7:0]  mem_wr_data_o;
  wire         miso = so_oe_o ? so_o : miso_t;
  wire         store_busy_pin_i = store_busy_pin_oe_o ? store_busy_pin_o : !ext_low;

  nvs_spi_host h (.clock_i, .miso_i(miso), .cs_n_o(cs_n_i), .sck_o(sck_i), .mosi_o(mosi_i),
    .hold_n_o(hold_n_i));
  nvs_slave dut (.clock_i, .nrst_i, .cs_n_i, .sck_i, .mosi_i, .hold_n_i, .so_o, .so_oe_o,
    .wp_n_i, .store_busy_pin_i, .store_busy_pin_o, .store_busy_pin_oe_o, .power_fail_i,
    .mem_rd_o, .mem_rd_addr_o, .mem_rdata_i, .mem_wr_valid_o, .mem_wr_ready_i, .mem_wr_addr_o,
    .mem_wr_data_o, .nv_store_o, .nv_recall_o, .nv_done_i, .busy_o, .write_enabled_o,
    .block_guard_bit0_o, .block_guard_bit1_o, .autosave_on_o, .overrun_o);

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] rnd8();
    seed = xs(seed);
    return seed[7:0] | 8'h80;
  endfunction
  function automatic logic guarded(input logic [16:0] ad, input logic [1:0] g);
    return g == 2'h3 || (g == 2'h2 && ad >= 17'h10000) || (g == 2'h1 && ad >= 17'h18000);
  endfunction
  // Array and nonvolatile side
  always @(posedge clock_i)
  begin
    if (mem_rd_o) mem_rdata_i <= mem[mem_rd_addr_o];
    if (mem_wr_valid_o && mem_wr_ready_i) mem[mem_wr_addr_o] <= mem_wr_data_o;
    if (nv_store_o) st_cnt <= st_cnt + 1;
    if (nv_recall_o) rc_cnt <= rc_cnt + 1;
  end
  always @(negedge clock_i)
  begin
    miso_t <= ~miso_t;
    stall <= xs(stall);
    mem_wr_ready_i <= stall[0] && !stall_on;
    nv_done_i <= nv_t == 1;
    nv_t <= (nv_store_o || nv_recall_o) ? 1000 : (nv_t > 0 ? nv_t - 1 : 0);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for empty buffer and idle nonvolatile side
  task automatic settle();
    for (int i = 0; i < 3000 && (mem_wr_valid_o || busy_o); i++) @(negedge clock_i);
    if (mem_wr_valid_o || busy_o)
    begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic op1(input logic [7:0] op);
    h.start(1'b1);
    h.xfer(op, 1'b0, r);
    h.stop();
  endtask
  task automatic two(input logic [7:0] op, input logic [7:0] b);
    h.start(1'b0);
    h.xfer(op, 1'b0, r);
    h.xfer(b, 1'b0, r);
    h.stop();
  endtask
  task automatic acc(input logic [7:0] op, input logic [23:0] ad, input int n,
                     input logic m3, input logic hld);
    h.start(m3);
    h.xfer(op, 1'b0, r);
    for (int i = 2; i >= 0; i--) h.xfer(ad[i*8 +: 8], 1'b0, r);
    for (int i = 0; i < n; i++)
    begin
      h.xfer(dq[i], hld && i == 1, r);
      rq[i] = r;
    end
    h.stop();
  endtask

  initial
  begin
    nrst_i = 1'b0;
    wp_n_i = 1'b1;
    power_fail_i = 1'b0;
    mem_wr_ready_i = 1'b0;
    nv_done_i = 1'b0;
    mem_rdata_i = 8'h00;
    ext_low = 1'b0;
    stall_on = 1'b0;
    miso_t = 1'b0;
    for (int i = 0; i < 131072; i++) mem[i] = 8'h00;
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (8) @(negedge clock_i);
    chk({busy_o, write_enabled_o, block_guard_bit1_o, block_guard_bit0_o, autosave_on_o},
        5'h01);
    for (int i = 0; i < 8; i++) dq[i] = rnd8();
    op1(8'h06);
    acc(8'h02, 24'hFFFFFF, 3, 1'b1, 1'b0);
    settle();
    chk(mem[17'h1FFFF], dq[0]);
    chk(mem[17'h00000], dq[1]);
    chk(mem[17'h00001], dq[2]);
    acc(8'h03, 24'h01FFFF, 3, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++) chk(rq[i], dq[i]);
    op1(8'h04);
    chk(write_enabled_o, 1'b0);
    acc(8'h02, 24'h000005, 1, 1'b1, 1'b0);
    op1(8'h06);
    wp_n_i = 1'b0;
    acc(8'h02, 24'h000006, 1, 1'b0, 1'b0);
    wp_n_i = 1'b1;
    settle();
    chk(mem[5], 8'h00);
    chk(mem[6], 8'h00);
    for (int g = 1; g < 4; g++)
    begin
      two(8'h01, {4'h0, g[1:0], 2'h0});
      chk({block_guard_bit1_o, block_guard_bit0_o}, g);
      for (int k = 0; k < 2; k++)
      begin
        a = (g == 1 ? 17'h18000 : g == 2 ? 17'h10000 : 17'h00000) - k;
        old = mem[a];
        dq[0] = ~old;
        acc(8'h02, {7'h00, a}, 1, 1'b1, 1'b0);
        settle();
        chk(mem[a], guarded(a, g[1:0]) ? old : dq[0]);
      end
    end
    two(8'h01, 8'h00);
    c0 = st_cnt;
    op1(8'h3C);
    chk(st_cnt, c0 + 1);
    chk(store_busy_pin_i, 1'b0);
    two(8'h05, 8'h00);
    chk(r[0], 1'b1);
    acc(8'h03, 24'h01FFFF, 1, 1'b0, 1'b0);
    chk(rq[0], 8'h00);
    settle();
    chk(store_busy_pin_i, 1'b1);
    c0 = st_cnt;
    for (int k = 0; k < 2; k++)
    begin
      ext_low = 1'b1;
      repeat (20) @(negedge clock_i);
      ext_low = 1'b0;
      chk(st_cnt, c0 + k);
      settle();
      acc(8'h02, 24'h000020, 1, 1'b1, 1'b0);
      settle();
    end
    c0 = st_cnt;
    for (int k = 0; k < 2; k++)
    begin
      op1(k ? 8'h59 : 8'h19);
      chk(autosave_on_o, k[0]);
      acc(8'h02, 24'h000021, 1, k[0], 1'b0);
      settle();
      power_fail_i = 1'b1;
      repeat (20) @(negedge clock_i);
      power_fail_i = 1'b0;
      chk(st_cnt, c0 + k);
      settle();
    end
    c0 = rc_cnt;
    op1(8'h60);
    chk(rc_cnt, c0 + 1);
    chk(busy_o, 1'b1);
    settle();
    for (int i = 0; i < 3; i++) dq[i] = rnd8();
    stall_on = 1'b1;
    acc(8'h02, 24'h000100, 3, 1'b1, 1'b0);
    chk({overrun_o, mem_wr_valid_o}, 2'h3);
    stall_on = 1'b0;
    settle();
    for (int i = 0; i < 3; i++) chk(mem[17'h100 + i], i < 2 ? dq[i] : 8'h00);
    for (int n = 0; n < 4; n++)
    begin
      seed = xs(seed);
      a = seed[16:0];
      for (int i = 0; i < 4; i++) dq[i] = rnd8();
      acc(8'h02, {seed[23:17], a}, 4, seed[24], 1'b0);
      settle();
      acc(8'h03, {7'h00, a}, 4, ~seed[24], 1'b0);
      for (int i = 0; i < 4; i++) chk(rq[i], dq[i]);
    end
    close_out();
  end
endmodule
`default_nettype wire
